// >>> logic/eebac_params.svh
// Offsets, field positions, reset values and timing counts of the byte-access controller
`ifndef EEBAC_PARAMS_SVH
`define EEBAC_PARAMS_SVH

// ----------------------------------------------------------------
// I/O register offsets
// ----------------------------------------------------------------
`define EEBAC_IO_ADDR_W 6
`define EEBAC_OFS_CONTROL 6'h1c
`define EEBAC_OFS_DATA 6'h1d
`define EEBAC_OFS_ADDRESS 6'h1e

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define EEBAC_BIT_READ_STROBE 0
`define EEBAC_BIT_WRITE_STROBE 1
`define EEBAC_BIT_MASTER_WE 2
`define EEBAC_RST_CONTROL 8'h00
`define EEBAC_RST_ADDRESS 8'h00
`define EEBAC_RST_DATA 8'h00

// ----------------------------------------------------------------
// Array geometry and timing
// ----------------------------------------------------------------
`define EEBAC_ARRAY_DEPTH 256
`define EEBAC_CLK_PERIOD_NS 8
`define EEBAC_T_WRITE_FAST_US 2500
`define EEBAC_T_WRITE_SLOW_US 4000
`define EEBAC_WRITE_FAST_CYCLES \
   ((`EEBAC_T_WRITE_FAST_US * 1000 + `EEBAC_CLK_PERIOD_NS - 1) / `EEBAC_CLK_PERIOD_NS)
`define EEBAC_WRITE_SLOW_CYCLES \
   ((`EEBAC_T_WRITE_SLOW_US * 1000 + `EEBAC_CLK_PERIOD_NS - 1) / `EEBAC_CLK_PERIOD_NS)
`define EEBAC_PROG_CNT_W 20
`define EEBAC_MWE_CYCLES 4
`define EEBAC_HALT_CYCLES 2

`endif

// >>> logic/eebac_pkg.sv
// Types shared by the byte-access controller and its array
`default_nettype none
`include "eebac_params.svh"

package eebac_pkg;

   // ----------------------------------------------------------------
   // Processor I/O request
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`EEBAC_IO_ADDR_W-1:0] addr;
      logic we;
      logic re;
      logic [7:0] wdata;
   } eebac_io_req_t;

   // ----------------------------------------------------------------
   // Array write port
   // ----------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } eebac_arr_wr_t;

   // ----------------------------------------------------------------
   // Controller state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic mwe;
      logic [1:0] mwe_cnt;
      logic wstrobe;
      logic rstrobe;
      logic [1:0] halt_cnt;
      logic [`EEBAC_PROG_CNT_W-1:0] prog_cnt;
      logic [7:0] prog_addr;
      logic [7:0] prog_data;
      logic [7:0] rdata;
   } eebac_state_t;

endpackage
`default_nettype wire

// >>> logic/eebac_array.sv
// 256-byte nonvolatile array model with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "eebac_params.svh"

module eebac_array #(
   parameter int DEPTH = `EEBAC_ARRAY_DEPTH
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire eebac_pkg::eebac_arr_wr_t wr,
   // Read port
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data
);

   generate
      if (DEPTH != 256) begin : g_bad_depth
         $error("eebac_array: depth must be 256 for an 8-bit address");
      end
   endgenerate

   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] rd_data_r;

   // Cell contents survive reset, as a nonvolatile store must
   always_ff @(posedge clk) begin
      if (wr.en) begin
         mem[wr.addr] <= wr.data;
      end
      rd_data_r <= mem[rd_addr];
   end

   assign rd_data = rd_data_r;

endmodule
`default_nettype wire

// >>> logic/eebac_ctrl.sv
// Byte-access controller for the on-chip nonvolatile array, reached through three I/O registers
`timescale 1ns/1ps
`default_nettype none
`include "eebac_params.svh"

module eebac_ctrl #(
   parameter int WRITE_FAST_CYCLES = `EEBAC_WRITE_FAST_CYCLES,
   parameter int WRITE_SLOW_CYCLES = `EEBAC_WRITE_SLOW_CYCLES
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Processor I/O access
   input wire eebac_pkg::eebac_io_req_t IO_REQ,
   output logic [7:0] IO_RDATA,
   // Processor stall
   output logic CPU_HALT,
   // Supply monitor
   input wire logic LOW_SUPPLY,
   input wire logic SLOW_SUPPLY,
   // Status
   output logic NV_BUSY
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int CNT_MAX = (1 << `EEBAC_PROG_CNT_W) - 1;

   generate
      if (WRITE_FAST_CYCLES < 2 || WRITE_FAST_CYCLES > CNT_MAX) begin : g_bad_fast
         $error("eebac_ctrl: WRITE_FAST_CYCLES out of range");
      end
      if (WRITE_SLOW_CYCLES < 2 || WRITE_SLOW_CYCLES > CNT_MAX) begin : g_bad_slow
         $error("eebac_ctrl: WRITE_SLOW_CYCLES out of range");
      end
      // The enable and stall counters are two bits wide
      if (`EEBAC_MWE_CYCLES < 1 || `EEBAC_MWE_CYCLES > 4) begin : g_bad_mwe
         $error("eebac_ctrl: enable window does not fit its counter");
      end
      if (`EEBAC_HALT_CYCLES < 1 || `EEBAC_HALT_CYCLES > 3) begin : g_bad_halt
         $error("eebac_ctrl: stall length does not fit its counter");
      end
   endgenerate

   localparam logic [`EEBAC_PROG_CNT_W-1:0] FAST_LOAD = `EEBAC_PROG_CNT_W'(WRITE_FAST_CYCLES);
   localparam logic [`EEBAC_PROG_CNT_W-1:0] SLOW_LOAD = `EEBAC_PROG_CNT_W'(WRITE_SLOW_CYCLES);
   localparam logic [`EEBAC_PROG_CNT_W-1:0] PROG_LAST = `EEBAC_PROG_CNT_W'(1);
   localparam logic [1:0] MWE_LAST = 2'(`EEBAC_MWE_CYCLES - 1);
   localparam logic [1:0] HALT_LOAD = 2'(`EEBAC_HALT_CYCLES);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   eebac_pkg::eebac_state_t state_r;
   eebac_pkg::eebac_state_t state_nxt;
   eebac_pkg::eebac_arr_wr_t arr_wr;
   logic [7:0] arr_rdata;

   logic wr_ctrl;
   logic wr_addr;
   logic wr_data;
   logic rd_hit;
   logic start_write;
   logic start_read;
   logic prog_done;
   logic [7:0] ctrl_view;

   always_comb begin
      wr_ctrl = IO_REQ.we && (IO_REQ.addr == `EEBAC_OFS_CONTROL);
      wr_addr = IO_REQ.we && (IO_REQ.addr == `EEBAC_OFS_ADDRESS);
      wr_data = IO_REQ.we && (IO_REQ.addr == `EEBAC_OFS_DATA);
      rd_hit = IO_REQ.re;
      // Enable must already stand; setting both bits in one write does not launch
      start_write = wr_ctrl && IO_REQ.wdata[`EEBAC_BIT_WRITE_STROBE] && state_r.mwe
                    && !state_r.wstrobe && !LOW_SUPPLY;
      // A read while programming would see a half-written cell, so it is refused
      start_read = wr_ctrl && IO_REQ.wdata[`EEBAC_BIT_READ_STROBE] && !state_r.wstrobe
                   && !state_r.rstrobe && !start_write;
      prog_done = state_r.wstrobe && (state_r.prog_cnt == PROG_LAST);
      ctrl_view = 8'h00;
      ctrl_view[`EEBAC_BIT_MASTER_WE] = state_r.mwe;
      ctrl_view[`EEBAC_BIT_WRITE_STROBE] = state_r.wstrobe;
      ctrl_view[`EEBAC_BIT_READ_STROBE] = state_r.rstrobe;
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;

      // Address and data registers
      if (wr_addr) begin
         state_nxt.addr = IO_REQ.wdata;
      end
      if (wr_data) begin
         state_nxt.data = IO_REQ.wdata;
      end

      // Master write enable with its own expiry
      if (wr_ctrl && IO_REQ.wdata[`EEBAC_BIT_MASTER_WE]) begin
         state_nxt.mwe = 1'b1;
         state_nxt.mwe_cnt = 2'h0;
      end else if (state_r.mwe) begin
         if (state_r.mwe_cnt == MWE_LAST) begin
            state_nxt.mwe = 1'b0;
            state_nxt.mwe_cnt = 2'h0;
         end else begin
            state_nxt.mwe_cnt = state_r.mwe_cnt + 2'h1;
         end
      end

      // Self-timed programming
      if (start_write) begin
         state_nxt.wstrobe = 1'b1;
         state_nxt.prog_cnt = SLOW_SUPPLY ? SLOW_LOAD : FAST_LOAD;
         state_nxt.prog_addr = state_r.addr;
         state_nxt.prog_data = state_r.data;
      end else if (state_r.wstrobe) begin
         if ((wr_addr || wr_data) || prog_done) begin
            state_nxt.wstrobe = 1'b0;
            state_nxt.prog_cnt = '0;
         end else begin
            state_nxt.prog_cnt = state_r.prog_cnt - PROG_LAST;
         end
      end

      // Read: the array has already registered the addressed byte
      if (start_read) begin
         state_nxt.rstrobe = 1'b1;
      end else if (state_r.rstrobe) begin
         state_nxt.data = arr_rdata;
         state_nxt.rstrobe = 1'b0;
      end

      // Processor stall after each launch
      // A refused strobe loads nothing, so software sees no stall for it
      if (start_write || start_read) begin
         state_nxt.halt_cnt = HALT_LOAD;
      end else if (state_r.halt_cnt != 2'h0) begin
         state_nxt.halt_cnt = state_r.halt_cnt - 2'h1;
      end

      // Register read-back
      if (rd_hit) begin
         case (IO_REQ.addr)
            `EEBAC_OFS_CONTROL: begin
               state_nxt.rdata = ctrl_view;
            end
            `EEBAC_OFS_ADDRESS: begin
               state_nxt.rdata = state_r.addr;
            end
            `EEBAC_OFS_DATA: begin
               state_nxt.rdata = state_r.data;
            end
            default: begin
               state_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         state_r.addr <= `EEBAC_RST_ADDRESS;
         state_r.data <= `EEBAC_RST_DATA;
         state_r.mwe <= 1'b0;
         state_r.mwe_cnt <= 2'h0;
         state_r.wstrobe <= 1'b0;
         state_r.rstrobe <= 1'b0;
         state_r.halt_cnt <= 2'h0;
         state_r.prog_cnt <= '0;
         state_r.prog_addr <= 8'h00;
         state_r.prog_data <= 8'h00;
         state_r.rdata <= 8'h00;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Array and outputs
   // ----------------------------------------------------------------
   // The cell is committed only at the end of the interval, so an abort leaves
   // it untouched and a low supply in the last cycle of the interval suppresses the commit.
   always_comb begin
      arr_wr.en = prog_done && !(wr_addr || wr_data) && !LOW_SUPPLY;
      arr_wr.addr = state_r.prog_addr;
      arr_wr.data = state_r.prog_data;
   end

   eebac_array #(
      .DEPTH(`EEBAC_ARRAY_DEPTH)
   ) u_array (
      .clk(SYS_CLK),
      .wr(arr_wr),
      .rd_addr(state_r.addr),
      .rd_data(arr_rdata)
   );

   assign IO_RDATA = state_r.rdata;
   assign CPU_HALT = (state_r.halt_cnt != 2'h0);
   // Busy is the write strobe bit itself, so polling either one gives the same answer
   assign NV_BUSY = state_r.wstrobe;

endmodule
`default_nettype wire

// >>> tb/eebac_ctrl_checker.sv
// Concurrent checks on the ports of the byte-access controller
`timescale 1ns/1ps
`default_nettype none
`include "eebac_params.svh"

module eebac_ctrl_checker #(
   parameter int WRITE_FAST_CYCLES = 2,
   parameter int WRITE_SLOW_CYCLES = 2
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Observed ports
   input wire eebac_pkg::eebac_io_req_t IO_REQ,
   input wire logic [7:0] IO_RDATA,
   input wire logic CPU_HALT,
   input wire logic LOW_SUPPLY,
   input wire logic SLOW_SUPPLY,
   input wire logic NV_BUSY
);
   logic [19:0] cnt_r;
   logic [2:0] mwe_r;
   logic slow_r;
   logic abort_r;
   logic ctrl_wr;
   logic data_wr;
   logic go;
   assign ctrl_wr = IO_REQ.we && IO_REQ.addr == `EEBAC_OFS_CONTROL;
   assign data_wr = IO_REQ.we && (IO_REQ.addr == `EEBAC_OFS_DATA || IO_REQ.addr == `EEBAC_OFS_ADDRESS);
   assign go = ctrl_wr && IO_REQ.wdata[1] && mwe_r != 3'h0 && !LOW_SUPPLY;
   // ----
   // Shadow of the enable window and of the busy run length
   // ----
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cnt_r <= 20'h0;
         mwe_r <= 3'h0;
         slow_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         cnt_r <= NV_BUSY ? cnt_r + 20'h1 : 20'h0;
         slow_r <= NV_BUSY ? slow_r : SLOW_SUPPLY;
         abort_r <= NV_BUSY && (abort_r || data_wr);
         mwe_r <= (ctrl_wr && IO_REQ.wdata[2]) ? 3'h4 : mwe_r - {2'h0, mwe_r != 3'h0};
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   sequence s_halt2;
      CPU_HALT [*2] ##1 !CPU_HALT;
   endsequence
   a_launch_taken: assert property (go && !NV_BUSY |=> NV_BUSY ##0 s_halt2)
      else $error("write launch not taken");
   a_launch_guard: assert property ($rose(NV_BUSY) |-> $past(go))
      else $error("write launched without enable");
   a_busy_length: assert property ($fell(NV_BUSY) && !abort_r |->
      cnt_r == (slow_r ? WRITE_SLOW_CYCLES : WRITE_FAST_CYCLES))
      else $error("busy length wrong");
   a_abort_stops: assert property (NV_BUSY && data_wr |=> !NV_BUSY)
      else $error("abort did not end write");
   a_low_blocks: assert property (LOW_SUPPLY && !NV_BUSY |=> !NV_BUSY)
      else $error("write started on low supply");
   a_ctrl_readback: assert property (IO_REQ.re && IO_REQ.addr == `EEBAC_OFS_CONTROL |=>
      IO_RDATA[7:3] == 5'h00 && IO_RDATA[1] == $past(NV_BUSY))
      else $error("control read value wrong");
   a_mwe_readback: assert property (IO_REQ.re && IO_REQ.addr == `EEBAC_OFS_CONTROL |=>
      IO_RDATA[2] == ($past(mwe_r) != 3'h0))
      else $error("enable read value wrong");
   a_rdata_holds: assert property (!IO_REQ.re |=> $stable(IO_RDATA))
      else $error("read data moved");
   a_read_halt: assert property (ctrl_wr && IO_REQ.wdata[0] && !IO_REQ.wdata[1] && !NV_BUSY && !CPU_HALT
      |=> s_halt2)
      else $error("read stall wrong");
endmodule

bind eebac_ctrl eebac_ctrl_checker #(.WRITE_FAST_CYCLES(WRITE_FAST_CYCLES), .WRITE_SLOW_CYCLES(WRITE_SLOW_CYCLES))
   i_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .CPU_HALT(CPU_HALT),
   .LOW_SUPPLY(LOW_SUPPLY), .SLOW_SUPPLY(SLOW_SUPPLY), .NV_BUSY(NV_BUSY));
`default_nettype wire

// >>> tb/eebac_cpu_model.sv
// Processor model issuing I/O register accesses and noting expected read data
`timescale 1ns/1ps
`default_nettype none
`include "eebac_params.svh"

module eebac_cpu_model (
   // Clock and status
   input wire logic clk,
   input wire logic halt,
   input wire logic busy,
   // I/O request
   output var eebac_pkg::eebac_io_req_t req
);
   logic [7:0] exp_q[$];
   // Waits that run out are counted so the bench can fail on them
   int limit_hits = 0;
   initial req = '0;
   // A stalled processor issues nothing until the stall ends or four cycles pass
   task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      if (halt === 1'b1) req = '0;
      while (halt === 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (halt === 1'b1) limit_hits++;
      req = {a, w, !w, d};
      @(posedge clk);
      #1;
   endtask
   task automatic idle();
      req = '0;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      idle();
      while (busy === 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (busy === 1'b1) limit_hits++;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(a, 1'b0, e);
      idle();
   endtask
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      wait_idle();
      acc(`EEBAC_OFS_ADDRESS, 1'b1, a);
      acc(`EEBAC_OFS_DATA, 1'b1, d);
      acc(`EEBAC_OFS_CONTROL, 1'b1, 8'h04);
      acc(`EEBAC_OFS_CONTROL, 1'b1, 8'h02);
      idle();
   endtask
   task automatic read_byte(input logic [7:0] a, input logic [7:0] e);
      wait_idle();
      acc(`EEBAC_OFS_ADDRESS, 1'b1, a);
      acc(`EEBAC_OFS_CONTROL, 1'b1, 8'h01);
      rd(`EEBAC_OFS_DATA, e);
   endtask
endmodule
`default_nettype wire

// >>> tb/test_eebac_ctrl.sv
// Self-checking bench for the byte-access controller
`timescale 1ns/1ps
`default_nettype none
`include "eebac_params.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module test_eebac_ctrl;
   localparam int FAST = 20;
   localparam int SLOW = 30;
   logic SYS_CLK, NRST, LOW_SUPPLY, SLOW_SUPPLY, CPU_HALT, NV_BUSY;
   eebac_pkg::eebac_io_req_t IO_REQ;
   logic [7:0] IO_RDATA, a, d, mexp;
   int err_count, total_checks, seed, n;
   eebac_ctrl #(.WRITE_FAST_CYCLES(FAST), .WRITE_SLOW_CYCLES(SLOW)) i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST),
      .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .CPU_HALT(CPU_HALT), .LOW_SUPPLY(LOW_SUPPLY),
      .SLOW_SUPPLY(SLOW_SUPPLY), .NV_BUSY(NV_BUSY));
   eebac_cpu_model i_cpu (.clk(SYS_CLK), .halt(CPU_HALT), .busy(NV_BUSY), .req(IO_REQ));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      #50000;
      err_count++;
      report_and_stop();
   end
   // Sampled just before the next edge so either update order gives the same answer
   always @(posedge SYS_CLK) begin
      if (IO_REQ.re === 1'b1) begin
         #6;
         mexp = i_cpu.exp_q.pop_front();
         `CHK("io_rdata", mexp, IO_RDATA)
      end
   end
   initial begin
      err_count = 0;
      total_checks = 0;
      seed = 32'h9f27;
      NRST = 1'b0;
      LOW_SUPPLY = 1'b0;
      SLOW_SUPPLY = 1'b0;
      repeat (3) @(posedge SYS_CLK);
      #1;
      NRST = 1'b1;
      i_cpu.rd(`EEBAC_OFS_CONTROL, `EEBAC_RST_CONTROL);
      i_cpu.rd(`EEBAC_OFS_ADDRESS, `EEBAC_RST_ADDRESS);
      i_cpu.rd(`EEBAC_OFS_DATA, `EEBAC_RST_DATA);
      i_cpu.rd(6'h3f, 8'h00);
      for (int k = 0; k < 2; k++) begin
         a = 8'($random(seed));
         d = 8'($random(seed));
         SLOW_SUPPLY = k[0];
         i_cpu.write_byte(a, d);
         n = 0;
         while (NV_BUSY === 1'b1 && n < 100) begin
            n++;
            @(posedge SYS_CLK);
            #1;
         end
         // The launch cycle is already gone when the write task returns
         `CHK("busy_cycles", (k ? SLOW : FAST) - 1, n)
         i_cpu.read_byte(a, d);
      end
      i_cpu.acc(`EEBAC_OFS_CONTROL, 1'b1, 8'hfa);
      i_cpu.rd(`EEBAC_OFS_CONTROL, 8'h00);
      // Enable reads back inside its window and has lapsed when the strobe comes in cycle five
      i_cpu.acc(`EEBAC_OFS_CONTROL, 1'b1, 8'h04);
      i_cpu.rd(`EEBAC_OFS_CONTROL, 8'h04);
      repeat (2) i_cpu.idle();
      i_cpu.acc(`EEBAC_OFS_CONTROL, 1'b1, 8'h02);
      i_cpu.rd(`EEBAC_OFS_CONTROL, 8'h00);
      LOW_SUPPLY = 1'b1;
      i_cpu.write_byte(a, ~d);
      `CHK("busy_low_supply", 1'b0, NV_BUSY)
      LOW_SUPPLY = 1'b0;
      i_cpu.read_byte(a, d);
      i_cpu.write_byte(a, ~d);
      i_cpu.acc(`EEBAC_OFS_DATA, 1'b1, 8'h33);
      i_cpu.idle();
      `CHK("busy_after_abort", 1'b0, NV_BUSY)
      i_cpu.read_byte(a, d);
      // A supply dip over the end of the interval must leave the old byte in place
      i_cpu.write_byte(a, ~d);
      LOW_SUPPLY = 1'b1;
      i_cpu.wait_idle();
      LOW_SUPPLY = 1'b0;
      i_cpu.read_byte(a, d);
      `CHK("cpu_wait_limits", 0, i_cpu.limit_hits)
      report_and_stop();
   end
endmodule
`default_nettype wire
